/* File: hw/output_divider_config.sv */
// register pair and active divider of the oscillator output stage
module output_divider_config (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic [8:0] active_div_setting_out,
  output logic [9:0] active_div_ratio_out,
  output logic div_setting_reserved_out,
  output logic [1:0] output_edge_speed_select_out,
  output logic prediv_by_five_out
);
  // ****************************************
  // reset views
  // ****************************************
  // the divider, its ratio and its flag come out of reset as if the reset
  // contents of both registers had just been loaded by an upper write
  localparam logic [8:0] DIV_SETTING_RESET =
    {outdiv_pkg::HIGH_CTRL_RESET[outdiv_pkg::DIV_MSB_BIT],
     outdiv_pkg::LOW_BYTE_RESET};
  localparam logic [9:0] DIV_RATIO_RESET =
    {1'b0, DIV_SETTING_RESET} + outdiv_pkg::DIV_RATIO_OFFSET;
  localparam logic DIV_RESERVED_RESET =
    DIV_SETTING_RESET < outdiv_pkg::DIV_MIN_VALID;

  // ****************************************
  // address decode
  // ****************************************
  logic hit_high;
  logic hit_low;
  logic wr_high;
  logic wr_low;
  logic rd_high;
  logic rd_low;
  logic rd_miss;

  assign hit_high = (addr_in == outdiv_pkg::ADDR_HIGH_CTRL);
  assign hit_low = (addr_in == outdiv_pkg::ADDR_LOW_BYTE);

  // write and read in one cycle both act: storage takes the write and
  // the read returns what was held before that edge
  assign wr_high = wr_en_in && hit_high;
  assign wr_low = wr_en_in && hit_low;
  assign rd_high = rd_en_in && hit_high;
  assign rd_low = rd_en_in && hit_low;
  assign rd_miss = rd_en_in && !hit_high && !hit_low;

  // ****************************************
  // upper register: output control and divider msb
  // ****************************************
  logic [1:0] edge_speed_q;
  logic prediv_q;
  logic [3:0] rsvd_q;
  logic div_msb_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      edge_speed_q <=
        outdiv_pkg::HIGH_CTRL_RESET[outdiv_pkg::EDGE_MSB:outdiv_pkg::EDGE_LSB];
    end else if (wr_high) begin
      edge_speed_q <=
        wr_data_in[outdiv_pkg::EDGE_MSB:outdiv_pkg::EDGE_LSB]; // see RULE5
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prediv_q <=
        outdiv_pkg::HIGH_CTRL_RESET[outdiv_pkg::PREDIV_BIT]; // see RULE6
    end else if (wr_high) begin
      prediv_q <= wr_data_in[outdiv_pkg::PREDIV_BIT]; // see RULE6
    end
  end

  // reserved bits are plain storage so software reads back what it wrote
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rsvd_q <=
        outdiv_pkg::HIGH_CTRL_RESET[outdiv_pkg::RSVD_MSB:outdiv_pkg::RSVD_LSB];
    end else if (wr_high) begin
      rsvd_q <= wr_data_in[outdiv_pkg::RSVD_MSB:outdiv_pkg::RSVD_LSB];
    end
  end

  // the msb copy only feeds read back; the divider takes its msb straight
  // from the write data
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_msb_q <=
        outdiv_pkg::HIGH_CTRL_RESET[outdiv_pkg::DIV_MSB_BIT]; // see RULE7
    end else if (wr_high) begin
      div_msb_q <= wr_data_in[outdiv_pkg::DIV_MSB_BIT]; // see RULE1
    end
  end

  // ****************************************
  // lower register
  // ****************************************
  logic [7:0] low_byte_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      low_byte_q <= outdiv_pkg::LOW_BYTE_RESET; // see RULE7
    end else if (wr_low) begin
      low_byte_q <= wr_data_in; // see RULE1
    end
  end

  // ****************************************
  // active divider
  // ****************************************
  logic [8:0] active_div_d;
  logic [8:0] active_div_q;

  // the lower byte only stages: all nine bits move in one edge on an
  // upper write, so the divider never runs a torn value; relies on the
  // host writing the lower byte first
  always_comb begin
    active_div_d = active_div_q;
    if (wr_high) begin
      active_div_d = {wr_data_in[outdiv_pkg::DIV_MSB_BIT],
                      low_byte_q}; // see RULE4 RULE3
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      active_div_q <= DIV_SETTING_RESET; // see RULE7
    end else begin
      active_div_q <= active_div_d; // see RULE1
    end
  end

  // ****************************************
  // divide ratio
  // ****************************************
  logic [9:0] div_ratio_d;
  logic [9:0] div_ratio_q;

  // registered from the next setting so the ratio moves on the same edge
  // as the setting and no adder sits on the output
  assign div_ratio_d =
    {1'b0, active_div_d} + outdiv_pkg::DIV_RATIO_OFFSET; // see RULE2

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_ratio_q <= DIV_RATIO_RESET;
    end else begin
      div_ratio_q <= div_ratio_d;
    end
  end

  // ****************************************
  // reserved setting flag
  // ****************************************
  logic div_reserved_d;
  logic div_reserved_q;

  // reserved settings are loaded all the same and only flagged; keeping
  // them off the divider is up to whatever programs it
  assign div_reserved_d =
    active_div_d < outdiv_pkg::DIV_MIN_VALID; // see RULE2

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      div_reserved_q <= DIV_RESERVED_RESET;
    end else begin
      div_reserved_q <= div_reserved_d;
    end
  end

  // ****************************************
  // read data view
  // ****************************************
  logic [7:0] high_ctrl_view;

  always_comb begin
    high_ctrl_view = 8'h00;
    high_ctrl_view[outdiv_pkg::EDGE_MSB:outdiv_pkg::EDGE_LSB] = edge_speed_q;
    high_ctrl_view[outdiv_pkg::PREDIV_BIT] = prediv_q;
    high_ctrl_view[outdiv_pkg::RSVD_MSB:outdiv_pkg::RSVD_LSB] = rsvd_q;
    high_ctrl_view[outdiv_pkg::DIV_MSB_BIT] = div_msb_q;
  end

  // ****************************************
  // read data register
  // ****************************************
  logic [7:0] rd_data_d;
  logic [7:0] rd_data_q;

  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_high) begin
      rd_data_d = high_ctrl_view;
    end else if (rd_low) begin
      rd_data_d = low_byte_q;
    end else if (rd_miss) begin
      rd_data_d = outdiv_pkg::RD_IDLE_DATA;
    end
  end

  // held until the next read strobe, so the host may pick it up late
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_data_q <= outdiv_pkg::RD_IDLE_DATA;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // output drive
  // ****************************************
  assign rd_data_out = rd_data_q;
  assign active_div_setting_out = active_div_q;
  assign active_div_ratio_out = div_ratio_q; // see RULE2
  assign div_setting_reserved_out = div_reserved_q; // see RULE2
  assign output_edge_speed_select_out = edge_speed_q; // see RULE5
  assign prediv_by_five_out = prediv_q; // see RULE6
endmodule : output_divider_config

/* File: hw/outdiv_pkg.sv */
// constants for the output divider configuration block
//
// How it works
// RULE1 - nine-bit divide setting: msb in upper register bit 0, low byte below
// RULE2 - output divides by setting plus one; settings 0 to 4 are reserved
// RULE3 - host writes the lower byte first, then the upper byte
// RULE4 - active divider loads all nine bits only when upper byte is written
// RULE5 - edge speed select 0 gives fast edges, 2 slow; resets to 0
// RULE6 - pre-divider select: clear divides by four, set by five; resets clear
// RULE7 - after reset the low byte reads 0x20 and the divider msb reads 0
package outdiv_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_HIGH_CTRL = 8'h16;
  localparam logic [7:0] ADDR_LOW_BYTE = 8'h17;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int EDGE_MSB = 7;
  localparam int EDGE_LSB = 6;
  localparam int PREDIV_BIT = 5;
  localparam int RSVD_MSB = 4;
  localparam int RSVD_LSB = 1;
  localparam int DIV_MSB_BIT = 0;
  localparam logic [1:0] EDGE_FAST = 2'h0;
  localparam logic [1:0] EDGE_SLOW = 2'h2;
  localparam logic [7:0] LOW_BYTE_RESET = 8'h20;
  localparam logic [7:0] HIGH_CTRL_RESET = 8'h00;
  localparam logic [8:0] DIV_MIN_VALID = 9'h005;
  localparam logic [9:0] DIV_RATIO_OFFSET = 10'h001;
  localparam logic [7:0] RD_IDLE_DATA = 8'h00;
endpackage : outdiv_pkg

/* File: dv/output_divider_config_properties.sv */
// checker for the output divider configuration block
module output_divider_config_properties (input wire logic ref_clk_in,
  sys_rst_in, wr_en_in, rd_en_in, div_setting_reserved_out,
  prediv_by_five_out, input wire logic [7:0] addr_in, wr_data_in,
  rd_data_out, input wire logic [8:0] active_div_setting_out,
  input wire logic [9:0] active_div_ratio_out,
  input wire logic [1:0] output_edge_speed_select_out);
  timeunit 1ns; timeprecision 100ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire [8:0] s = active_div_setting_out;
  wire [3:0] c = {output_edge_speed_select_out, prediv_by_five_out, s[8]};
  wire hi = wr_en_in && addr_in == 8'h16;
  wire [3:0] wf = {wr_data_in[7:5], wr_data_in[0]};
  property p_hi; hi |=> c == $past(wf); endproperty
  a_hi: assert property (p_hi) else $error("upper");
  property p_lo; !hi |=> $stable(s); endproperty
  a_lo: assert property (p_lo) else $error("load");
  property p_id; !hi |=> $stable(c); endproperty
  a_id: assert property (p_id) else $error("ctrl");
  property p_rt; active_div_ratio_out == 10'(s) + 10'h001; endproperty
  a_rt: assert property (p_rt) else $error("ratio");
  property p_rv; div_setting_reserved_out == (s < 9'h005); endproperty
  a_rv: assert property (p_rv) else $error("rsv");
  property p_rs; disable iff (1'b0) sys_rst_in |=> s == 9'h020 && !c &&
    rd_data_out == 8'h00; endproperty
  a_rs: assert property (p_rs) else $error("reset");
  c_hi: cover property (hi);
  c_rv: cover property (div_setting_reserved_out);
  c_rd: cover property (rd_en_in);
endmodule : output_divider_config_properties
bind output_divider_config output_divider_config_properties
  output_divider_config_properties_i (.*);

/* File: dv/outdiv_host.sv */
// host model issuing register strobes; released lines show inverted data
module outdiv_host (input wire logic ref_clk_in,
  input wire logic [7:0] rd_data_in, output logic wr_en_out, rd_en_out,
  output logic [7:0] addr_out, wr_data_out);
  timeunit 1ns; timeprecision 100ps;
  initial {wr_en_out, rd_en_out, addr_out, wr_data_out} = '0;
  task automatic xfer(logic w, logic [7:0] a, d, output logic [7:0] q);
    @(posedge ref_clk_in) #1 {wr_en_out, rd_en_out} = {w, !w};
    {addr_out, wr_data_out} = {a, d};
    @(posedge ref_clk_in) #1 {wr_en_out, rd_en_out} = 2'h0;
    {addr_out, wr_data_out} = ~{a, d};
    q = rd_data_in;
  endtask : xfer
endmodule : outdiv_host

/* File: dv/output_divider_config_tb.sv */
// self-checking bench for the output divider configuration block
module output_divider_config_tb;
  timeunit 1ns; timeprecision 100ps;
  logic ref_clk_in = 0, sys_rst_in = 1, wr, rd, v, p;
  logic [7:0] addr, wd, rdo, q;
  logic [8:0] s; logic [9:0] r; logic [1:0] e;
  int errors = 0, checks = 0, cyc = 0;
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  output_divider_config output_divider_config_i (.ref_clk_in, .sys_rst_in,
    .wr_en_in(wr), .rd_en_in(rd), .addr_in(addr), .wr_data_in(wd),
    .rd_data_out(rdo), .active_div_setting_out(s), .active_div_ratio_out(r),
    .div_setting_reserved_out(v), .output_edge_speed_select_out(e),
    .prediv_by_five_out(p));
  outdiv_host outdiv_host_i (.ref_clk_in, .rd_data_in(rdo), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(addr), .wr_data_out(wd));
  task automatic chk(string n, logic [9:0] x, y);
    checks++;
    if (x !== y) begin
      errors++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task wrap_up;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // bound well above the ~36 cycles the sequence needs
  always @(posedge ref_clk_in) if (++cyc == 400) begin
    errors++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    #1 sys_rst_in = 0;
    outdiv_host_i.xfer(1'b0, 8'h17, 8'h00, q);
    chk("low", 10'h020, q);
    outdiv_host_i.xfer(1'b0, 8'h16, 8'h00, q);
    chk("high", 10'h000, q);
    outdiv_host_i.xfer(1'b1, 8'h17, 8'hFF, q);
    chk("early", 10'h020, s);
    outdiv_host_i.xfer(1'b0, 8'h17, 8'h00, q);
    chk("low_back", 10'h0FF, q);
    outdiv_host_i.xfer(1'b1, 8'h16, 8'hA1, q);
    chk("ratio", 10'h200, r);
    chk("ctrl", 10'h005, {e, p});
    outdiv_host_i.xfer(1'b0, 8'h16, 8'h00, q);
    chk("high_back", 10'h0A1, q);
    outdiv_host_i.xfer(1'b1, 8'h17, 8'h05, q);
    outdiv_host_i.xfer(1'b1, 8'h16, 8'h00, q);
    chk("least", 10'h006, r);
    chk("valid", 10'h000, v);
    outdiv_host_i.xfer(1'b1, 8'h17, 8'h04, q);
    outdiv_host_i.xfer(1'b1, 8'h16, 8'h00, q);
    chk("rsv", 10'h008, {v, e, p});
    outdiv_host_i.xfer(1'b0, 8'h18, 8'h00, q);
    chk("unmapped", 10'h000, q);
    sys_rst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 sys_rst_in = 1'b0;
    outdiv_host_i.xfer(1'b0, 8'h17, 8'h00, q);
    chk("rst_low", 10'h020, q);
    chk("rst_div", 10'h020, s);
    chk("rst_ctrl", 10'h000, {v, e, p});
    wrap_up;
  end
endmodule : output_divider_config_tb
